/* core/bpcd_top.sv */
// Two bidirectional ports with direction, latch and pin registers on a Wishbone slave.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module bpcd_top #(
    parameter int PORT_W = bpcd_pkg::BPCD_PORT_W
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output var  logic [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        capcmp2_route_option,
    input  wire bpcd_pkg::bpcd_c_ovr_t       c_ovr,
    output bpcd_pkg::bpcd_c_periph_in_t      c_periph_in,
    output logic                             capcmp2_on_c,
    input  wire logic [PORT_W-1:0]           c_pin_i,
    output logic [PORT_W-1:0]                c_pin_o,
    output logic [PORT_W-1:0]                c_pin_oe_n,
    input  wire logic [PORT_W-1:0]           d_pin_i,
    output logic [PORT_W-1:0]                d_pin_o,
    output logic [PORT_W-1:0]                d_pin_oe_n,
    input  wire bpcd_pkg::bpcd_slave_flags_t slave_flags,
    input  wire bpcd_pkg::bpcd_slave_out_t   slave_out,
    output logic [PORT_W-1:0]                parallel_slave_data,
    output logic                             slave_port_select,
    output logic [bpcd_pkg::BPCD_E_DIR_W-1:0] e_direction
);

    bpcd_pkg::bpcd_bus_state_t bus_state;
    bpcd_pkg::bpcd_bus_state_t next_bus_state;

    logic [PORT_W-1:0] c_direction;
    logic [PORT_W-1:0] c_out_latch;
    logic [PORT_W-1:0] d_direction;
    logic [PORT_W-1:0] d_out_latch;
    logic [bpcd_pkg::BPCD_E_DIR_W-1:0] e_dir_bits;
    logic              slave_mode;
    logic              route_opt;

    logic [PORT_W-1:0] c_pins;
    logic [PORT_W-1:0] d_pins;

    logic [PORT_W-1:0] c_ovr_en;
    logic [PORT_W-1:0] c_ovr_dir_in;
    logic [PORT_W-1:0] c_ovr_out;
    logic [PORT_W-1:0] d_ovr_en;
    logic [PORT_W-1:0] d_ovr_dir_in;
    logic [PORT_W-1:0] d_ovr_out;

    // Bus request decoding.
    wire       bus_req;
    wire       bus_take;
    wire       wr_take;
    wire [7:0] wr_byte;
    wire       hit_c_pins;
    wire       hit_c_latch;
    wire       hit_c_dir;
    wire       hit_d_pins;
    wire       hit_d_latch;
    wire       hit_d_dir;
    wire       hit_e_ctrl;
    wire       hit_status;
    wire [7:0] e_ctrl_value;
    wire [7:0] status_value;
    wire [7:0] read_value;

    // Widens an 8-bit port value to the register byte.
    function automatic logic [7:0] bpcd_byte(input logic [PORT_W-1:0] v);
        logic [7:0] r;
        r = '0;
        r[PORT_W-1:0] = v;
        return r;
    endfunction

    // Matches the word address, ignoring the byte-offset bits.
    function automatic logic bpcd_hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr[7:2] == ofs[7:2];
    endfunction

    assign bus_req  = wb_cyc_i && wb_stb_i;
    assign bus_take = bus_req && (bus_state == bpcd_pkg::BPCD_BUS_IDLE);
    assign wr_take  = bus_take && wb_we_i && wb_sel_i[0];
    assign wr_byte  = wb_dat_i[7:0];

    assign hit_c_pins  = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_C_PINS);
    assign hit_c_latch = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_C_LATCH);
    assign hit_c_dir   = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_C_DIR);
    assign hit_d_pins  = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_D_PINS);
    assign hit_d_latch = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_D_LATCH);
    assign hit_d_dir   = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_D_DIR);
    assign hit_e_ctrl  = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_E_CTRL);
    assign hit_status  = bpcd_hit(wb_adr_i, bpcd_pkg::BPCD_OFS_STATUS);

    // Control byte: slave flags, mode bit, a zero hole at bit 3, direction bits.
    assign e_ctrl_value = {slave_flags.input_buffer_full,
                           slave_flags.output_buffer_full,
                           slave_flags.input_buffer_overflow,
                           slave_mode,
                           1'b0,
                           e_dir_bits};

    // Status byte shows the slave mode bit and the route option.
    assign status_value = {6'h00, slave_mode, route_opt};

    // Pin reads return synchronised levels, latch reads the stored value.
    assign read_value = hit_c_pins  ? bpcd_byte(c_pins)      :
                        hit_c_latch ? bpcd_byte(c_out_latch) :
                        hit_c_dir   ? bpcd_byte(c_direction) :
                        hit_d_pins  ? bpcd_byte(d_pins)      :
                        hit_d_latch ? bpcd_byte(d_out_latch) :
                        hit_d_dir   ? bpcd_byte(d_direction) :
                        hit_e_ctrl  ? e_ctrl_value           :
                        hit_status  ? status_value           :
                        8'h00;

    // Single-wait-state slave: ack one cycle after the request, then idle.
    always_comb begin
        case (bus_state)
            bpcd_pkg::BPCD_BUS_IDLE: begin
                next_bus_state = bus_req ? bpcd_pkg::BPCD_BUS_ACK : bpcd_pkg::BPCD_BUS_IDLE;
            end
            bpcd_pkg::BPCD_BUS_ACK: begin
                next_bus_state = bpcd_pkg::BPCD_BUS_IDLE;
            end
            default: begin
                next_bus_state = bpcd_pkg::BPCD_BUS_IDLE;
            end
        endcase
    end

    assign wb_ack_o = (bus_state == bpcd_pkg::BPCD_BUS_ACK);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_state <= bpcd_pkg::BPCD_BUS_IDLE;
            wb_dat_o  <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            if (bus_take) begin
                wb_dat_o <= {24'h00_0000, read_value};
            end
        end
    end

    // Direction and control registers return to their defaults on every reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            c_direction <= bpcd_pkg::BPCD_DIR_RESET[PORT_W-1:0];
            d_direction <= bpcd_pkg::BPCD_DIR_RESET[PORT_W-1:0];
            e_dir_bits  <= bpcd_pkg::BPCD_E_DIR_RESET;
            slave_mode  <= bpcd_pkg::BPCD_SLAVE_RESET;
        end else if (wr_take) begin
            if (hit_c_dir) begin
                c_direction <= wr_byte[PORT_W-1:0];
            end else if (hit_d_dir) begin
                d_direction <= wr_byte[PORT_W-1:0];
            end else if (hit_e_ctrl) begin
                e_dir_bits <= wr_byte[bpcd_pkg::BPCD_E_DIR_W-1:0];
                slave_mode <= wr_byte[bpcd_pkg::BPCD_E_SLAVE_BIT];
            end
        end
    end

    // Output latches have no reset so their contents survive a reset.
    always_ff @(posedge sys_clk) begin
        if (wr_take && (hit_c_pins || hit_c_latch)) begin
            c_out_latch <= wr_byte[PORT_W-1:0];
        end
        if (wr_take && (hit_d_pins || hit_d_latch)) begin
            d_out_latch <= wr_byte[PORT_W-1:0];
        end
    end

    // The route option is nonvolatile configuration, followed each cycle.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            route_opt <= bpcd_pkg::BPCD_ROUTE_RESET;
        end else begin
            route_opt <= capcmp2_route_option;
        end
    end

    assign capcmp2_on_c = route_opt;

    // Gathers the peripheral claims onto the pins of the first port.
    assign c_ovr_en = {c_ovr.rx.en,
                       c_ovr.tx.en,
                       c_ovr.sdo.en,
                       c_ovr.sdi.en,
                       c_ovr.sck.en,
                       c_ovr.capcmp1.en,
                       c_ovr.capcmp2.en && route_opt,
                       c_ovr.tmr1.en};

    assign c_ovr_dir_in = {c_ovr.rx.dir_in,
                           c_ovr.tx.dir_in,
                           c_ovr.sdo.dir_in,
                           c_ovr.sdi.dir_in,
                           c_ovr.sck.dir_in,
                           c_ovr.capcmp1.dir_in,
                           c_ovr.capcmp2.dir_in,
                           c_ovr.tmr1.dir_in};

    assign c_ovr_out = {c_ovr.rx.out,
                        c_ovr.tx.out,
                        c_ovr.sdo.out,
                        c_ovr.sdi.out,
                        c_ovr.sck.out,
                        c_ovr.capcmp1.out,
                        c_ovr.capcmp2.out,
                        c_ovr.tmr1.out};

    // Peripheral inputs read the synchronised pin levels at their bit positions; capcmp2 reads its pin only while route_opt is set.
    assign c_periph_in.tmr1_clk = c_pins[bpcd_pkg::BPCD_C_TMR1];
    assign c_periph_in.capcmp2  = route_opt && c_pins[bpcd_pkg::BPCD_C_CAPCMP2];
    assign c_periph_in.capcmp1  = c_pins[bpcd_pkg::BPCD_C_CAPCMP1];
    assign c_periph_in.sck      = c_pins[bpcd_pkg::BPCD_C_SCK];
    assign c_periph_in.sdi      = c_pins[bpcd_pkg::BPCD_C_SDI];
    assign c_periph_in.rx       = c_pins[bpcd_pkg::BPCD_C_RX];
    assign c_periph_in.ck       = c_pins[bpcd_pkg::BPCD_C_TX];

    // In slave mode the slave logic owns the second port's drivers.
    generate
        genvar n;
        for (n = 0; n < PORT_W; n++) begin : g_slave
            assign d_ovr_en[n]     = slave_mode;
            assign d_ovr_dir_in[n] = ~slave_out.drive;
            assign d_ovr_out[n]    = slave_out.data[n];
            assign parallel_slave_data[n] = slave_mode && d_pins[n];
        end
    endgenerate

    assign slave_port_select = slave_mode;
    assign e_direction       = e_dir_bits;

    bpcd_pin_cell #(
        .WIDTH (PORT_W)
    ) u_port_c (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .dir_reg    (c_direction),
        .latch      (c_out_latch),
        .ovr_en     (c_ovr_en),
        .ovr_dir_in (c_ovr_dir_in),
        .ovr_out    (c_ovr_out),
        .pin_i      (c_pin_i),
        .pin_o      (c_pin_o),
        .pin_oe_n   (c_pin_oe_n),
        .pin_sync   (c_pins)
    );

    bpcd_pin_cell #(
        .WIDTH (PORT_W)
    ) u_port_d (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .dir_reg    (d_direction),
        .latch      (d_out_latch),
        .ovr_en     (d_ovr_en),
        .ovr_dir_in (d_ovr_dir_in),
        .ovr_out    (d_ovr_out),
        .pin_i      (d_pin_i),
        .pin_o      (d_pin_o),
        .pin_oe_n   (d_pin_oe_n),
        .pin_sync   (d_pins)
    );

endmodule
`default_nettype wire

/* pkg/bpcd_pkg.sv */
// Constants, types and register map of the two bidirectional ports.
package bpcd_pkg;

    localparam int BPCD_PORT_W = 8;
    localparam int BPCD_E_DIR_W = 3;

    localparam logic [7:0] BPCD_OFS_C_PINS   = 8'h00;
    localparam logic [7:0] BPCD_OFS_C_LATCH  = 8'h04;
    localparam logic [7:0] BPCD_OFS_C_DIR    = 8'h08;
    localparam logic [7:0] BPCD_OFS_D_PINS   = 8'h0C;
    localparam logic [7:0] BPCD_OFS_D_LATCH  = 8'h10;
    localparam logic [7:0] BPCD_OFS_D_DIR    = 8'h14;
    localparam logic [7:0] BPCD_OFS_E_CTRL   = 8'h18;
    localparam logic [7:0] BPCD_OFS_STATUS   = 8'h1C;

    localparam logic [7:0] BPCD_DIR_RESET    = 8'hFF;
    localparam logic [2:0] BPCD_E_DIR_RESET  = 3'h7;
    localparam logic       BPCD_SLAVE_RESET  = 1'b0;
    localparam logic       BPCD_ROUTE_RESET  = 1'b1;

    localparam int BPCD_E_SLAVE_BIT = 4;
    localparam int BPCD_E_INPUT_BUFFER_OVERFLOW_BIT  = 5;
    localparam int BPCD_E_OBF_BIT   = 6;
    localparam int BPCD_E_IBF_BIT   = 7;

    localparam int BPCD_C_TMR1    = 0;
    localparam int BPCD_C_CAPCMP2 = 1;
    localparam int BPCD_C_CAPCMP1 = 2;
    localparam int BPCD_C_SCK     = 3;
    localparam int BPCD_C_SDI     = 4;
    localparam int BPCD_C_SDO     = 5;
    localparam int BPCD_C_TX      = 6;
    localparam int BPCD_C_RX      = 7;

    typedef enum logic {
        BPCD_BUS_IDLE = 1'b0,
        BPCD_BUS_ACK  = 1'b1
    } bpcd_bus_state_t;

    // One peripheral's claim on a pin; dir_in is one for input.
    typedef struct packed {
        logic en;
        logic dir_in;
        logic out;
    } bpcd_ovr_t;

    typedef struct packed {
        bpcd_ovr_t rx;
        bpcd_ovr_t tx;
        bpcd_ovr_t sdo;
        bpcd_ovr_t sdi;
        bpcd_ovr_t sck;
        bpcd_ovr_t capcmp1;
        bpcd_ovr_t capcmp2;
        bpcd_ovr_t tmr1;
    } bpcd_c_ovr_t;

    typedef struct packed {
        logic tmr1_clk;
        logic capcmp2;
        logic capcmp1;
        logic sck;
        logic sdi;
        logic rx;
        logic ck;
    } bpcd_c_periph_in_t;

    typedef struct packed {
        logic input_buffer_full;
        logic output_buffer_full;
        logic input_buffer_overflow;
    } bpcd_slave_flags_t;

    typedef struct packed {
        logic       drive;
        logic [7:0] data;
    } bpcd_slave_out_t;

endpackage

/* core/bpcd_pin_cell.sv */
// Pin drivers and input synchronisers for one group of port pins.
`timescale 1ns/100ps
`default_nettype none
module bpcd_pin_cell #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] dir_reg,
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] ovr_en,
    input  wire logic [WIDTH-1:0] ovr_dir_in,
    input  wire logic [WIDTH-1:0] ovr_out,
    input  wire logic [WIDTH-1:0] pin_i,
    output var  logic [WIDTH-1:0] pin_o,
    output var  logic [WIDTH-1:0] pin_oe_n,
    output var  logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] eff_dir_in;
    logic [WIDTH-1:0] eff_out;
    logic [WIDTH-1:0] sync_first;

    // The override only steers the pin; the direction register is untouched.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign eff_dir_in[i] = ovr_en[i] ? ovr_dir_in[i] : dir_reg[i];
            assign eff_out[i]    = ovr_en[i] ? ovr_out[i] : latch[i];
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_oe_n   <= '1;
            pin_o      <= '0;
            sync_first <= '0;
            pin_sync   <= '0;
        end else begin
            pin_oe_n   <= eff_dir_in;
            pin_o      <= eff_out;
            sync_first <= pin_i;
            pin_sync   <= sync_first;
        end
    end

endmodule
`default_nettype wire

/* verification/bpcd_top_sva.sv */
// Concurrent checks on the ports of the two-port block.
`timescale 1ns/100ps
`default_nettype none
module bpcd_top_sva #(
    parameter int PORT_W = 8
) (
    input wire logic                                 sys_clk,
    input wire logic                                 reset,
    input wire logic                                 wb_cyc_i,
    input wire logic                                 wb_stb_i,
    input wire logic                                 wb_we_i,
    input wire logic [7:0]                           wb_adr_i,
    input wire logic [3:0]                           wb_sel_i,
    input wire logic [31:0]                          wb_dat_i,
    input wire logic [31:0]                          wb_dat_o,
    input wire logic                                 wb_ack_o,
    input wire logic                                 capcmp2_route_option,
    input wire bpcd_pkg::bpcd_c_ovr_t                c_ovr,
    input wire logic                                 capcmp2_on_c,
    input wire logic [PORT_W-1:0]                    c_pin_o,
    input wire logic [PORT_W-1:0]                    c_pin_oe_n,
    input wire logic [PORT_W-1:0]                    d_pin_o,
    input wire logic [PORT_W-1:0]                    d_pin_oe_n,
    input wire bpcd_pkg::bpcd_slave_out_t            slave_out,
    input wire logic [PORT_W-1:0]                    parallel_slave_data,
    input wire logic                                 slave_port_select,
    input wire logic [bpcd_pkg::BPCD_E_DIR_W-1:0]    e_direction
);
    logic wr;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_reset_dirs: assert property (
        $fell(reset) |-> c_pin_oe_n == 8'hFF && d_pin_oe_n == 8'hFF && e_direction == 3'h7 && !slave_port_select)
        else $error("pins not inputs after reset");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
    a_dir_to_pins: assert property (
        wr && wb_adr_i[7:2] == 6'h05 && !slave_port_select |-> ##2 d_pin_oe_n == $past(wb_dat_i[7:0], 2))
        else $error("direction write not on pins");
    a_latch_to_pins: assert property (
        wr && (wb_adr_i[7:2] == 6'h04 || wb_adr_i[7:2] == 6'h03) && !slave_port_select
        |-> ##2 d_pin_o == $past(wb_dat_i[7:0], 2)) else $error("latch write not on pins");
    a_ovr_output: assert property (
        c_ovr.capcmp1.en && !c_ovr.capcmp1.dir_in |=> !c_pin_oe_n[2] && c_pin_o[2] == $past(c_ovr.capcmp1.out))
        else $error("output override ignored");
    a_ovr_input: assert property (c_ovr.sdo.en && c_ovr.sdo.dir_in |=> c_pin_oe_n[5])
        else $error("input override ignored");
    a_slave_release: assert property (slave_port_select && !slave_out.drive |=> d_pin_oe_n == 8'hFF)
        else $error("slave mode pins driven");
    a_gpio_no_data: assert property ((!slave_port_select) [*4] |-> parallel_slave_data == 8'h00)
        else $error("slave data outside slave mode");
    a_route_follow: assert property (!$past(reset) |-> capcmp2_on_c == $past(capcmp2_route_option))
        else $error("route option not followed");
endmodule
bind bpcd_top bpcd_top_sva #(.PORT_W(PORT_W)) u_bpcd_sva (.*);
`default_nettype wire

/* verification/bpcd_pin_partner.sv */
// External circuitry on one port: drives every pin that the block releases.
`timescale 1ns/100ps
`default_nettype none
module bpcd_pin_partner (
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_val,
    output var  logic [7:0] pin_i
);
    assign pin_i = (pin_oe_n & ext_val) | (~pin_oe_n & pin_o);
endmodule
`default_nettype wire

/* verification/tb_bidir_port_c_d.sv */
// Self-checking bench for the two bidirectional ports.
`timescale 1ns/100ps
`default_nettype none
module tb_bidir_port_c_d;
    logic                        sys_clk;
    logic                        reset;
    logic                        cyc;
    logic                        stb;
    logic                        we;
    logic                        route;
    logic                        slave_sel;
    logic                        capcmp2_on_c;
    logic [7:0]                  adr;
    logic [31:0]                 wdat;
    logic [31:0]                 rdat;
    logic [31:0]                 q;
    logic                        ack;
    logic [7:0]                  c_pin_i, c_pin_o, c_pin_oe_n, d_pin_i, d_pin_o, d_pin_oe_n, slave_data;
    logic [2:0]                  e_dir;
    bpcd_pkg::bpcd_c_ovr_t       c_ovr;
    bpcd_pkg::bpcd_c_periph_in_t periph;
    int                          failures;
    int                          n_checks;

    bpcd_top DUT (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .capcmp2_route_option(route), .c_ovr(c_ovr), .c_periph_in(periph), .capcmp2_on_c(capcmp2_on_c),
        .c_pin_i(c_pin_i), .c_pin_o(c_pin_o), .c_pin_oe_n(c_pin_oe_n), .d_pin_i(d_pin_i), .d_pin_o(d_pin_o),
        .d_pin_oe_n(d_pin_oe_n), .slave_flags(3'h5), .slave_out(9'h000), .parallel_slave_data(slave_data),
        .slave_port_select(slave_sel), .e_direction(e_dir));
    bpcd_pin_partner c_side (.pin_o(c_pin_o), .pin_oe_n(c_pin_oe_n), .ext_val(8'h3E), .pin_i(c_pin_i));
    bpcd_pin_partner d_side (.pin_o(d_pin_o), .pin_oe_n(d_pin_oe_n), .ext_val(8'hC3), .pin_i(d_pin_i));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The request stands until ack is sampled high at a rising edge; only the watchdog ends a hung wait.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask

    task automatic t_reset(input logic kept, input logic [7:0] lat);
        rd("c_direction", bpcd_pkg::BPCD_OFS_C_DIR, 32'hFF);
        rd("d_direction", bpcd_pkg::BPCD_OFS_D_DIR, 32'hFF);
        rd("e_ctrl", bpcd_pkg::BPCD_OFS_E_CTRL, 32'hA7);
        chk("c_pin_oe_n", 32'hFF, {24'h0, c_pin_oe_n});
        chk("slave_sel", 32'h0, {31'h0, slave_sel});
        if (kept) rd("c_out_latch", bpcd_pkg::BPCD_OFS_C_LATCH, {24'h0, lat});
    endtask

    task automatic t_pins();
        wb(1'b1, bpcd_pkg::BPCD_OFS_C_LATCH, 8'h5A);
        rd("c_out_latch", bpcd_pkg::BPCD_OFS_C_LATCH, 32'h5A);
        wb(1'b1, bpcd_pkg::BPCD_OFS_C_DIR, 8'h0F);
        @(negedge sys_clk);
        chk("c_pin_oe_n", 32'h0F, {24'h0, c_pin_oe_n});
        chk("c_pin_o", 32'h5, {28'h0, c_pin_o[7:4]});
        // Pin levels need two synchroniser edges before a read can see them.
        repeat (2) @(posedge sys_clk);
        rd("c_pins", bpcd_pkg::BPCD_OFS_C_PINS, 32'h5E);
        chk("sck_in", 32'h1, {31'h0, periph.sck});
        wb(1'b1, bpcd_pkg::BPCD_OFS_C_PINS, 8'h00);
        rd("c_out_latch", bpcd_pkg::BPCD_OFS_C_LATCH, 32'h0);
    endtask

    task automatic t_ovr();
        @(posedge sys_clk);
        c_ovr.capcmp1 <= 3'h5;
        c_ovr.sdo <= 3'h6;
        repeat (2) @(negedge sys_clk);
        chk("capcmp1_drive", 32'h1, {31'h0, c_pin_o[2] & ~c_pin_oe_n[2]});
        chk("sdo_release", 32'h1, {31'h0, c_pin_oe_n[5]});
        rd("c_direction", bpcd_pkg::BPCD_OFS_C_DIR, 32'h0F);
        c_ovr <= '0;
    endtask

    task automatic t_slave();
        wb(1'b1, bpcd_pkg::BPCD_OFS_D_DIR, 8'h00);
        wb(1'b1, bpcd_pkg::BPCD_OFS_D_LATCH, 8'h81);
        @(negedge sys_clk);
        chk("d_pin_o", 32'h81, {24'h0, d_pin_o & ~d_pin_oe_n});
        wb(1'b1, bpcd_pkg::BPCD_OFS_E_CTRL, 8'h1D);
        route <= 1'b0;
        rd("e_ctrl", bpcd_pkg::BPCD_OFS_E_CTRL, 32'hB5);
        chk("slave_sel", 32'h1, {31'h0, slave_sel});
        chk("e_dir", 32'h5, {29'h0, e_dir});
        chk("d_pin_oe_n", 32'hFF, {24'h0, d_pin_oe_n});
        chk("slave_data", 32'hC3, {24'h0, slave_data});
        rd("d_direction", bpcd_pkg::BPCD_OFS_D_DIR, 32'h0);
        rd("status", bpcd_pkg::BPCD_OFS_STATUS, 32'h2);
        chk("capcmp2_in", 32'h0, {31'h0, periph.capcmp2});
        chk("capcmp2_on_c", 32'h0, {31'h0, capcmp2_on_c});
        rd("unmapped", 8'h40, 32'h0);
        route <= 1'b1;
        rd("status", bpcd_pkg::BPCD_OFS_STATUS, 32'h3);
        chk("capcmp2_in", 32'h1, {31'h0, periph.capcmp2});
        chk("capcmp2_on_c", 32'h1, {31'h0, capcmp2_on_c});
    endtask

    initial begin
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        route = 1'b1;
        c_ovr = '0;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset(1'b0, 8'h00);
        t_pins();
        t_ovr();
        t_slave();
        wb(1'b1, bpcd_pkg::BPCD_OFS_C_LATCH, 8'hA5);
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset(1'b1, 8'hA5);
        finish_test();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
